// ### pkg/b8t_defs.svh
// register offsets, field positions and reset values of the basic timer
// Notes on behaviour
// - 8-bit up-counter restarts from zero after reaching reload value and raises update on overflow
// - prescaler is a 16-bit counter dividing by two to the 4-bit setting
// - prescale setting has preload and shadow copies; reads return preload
// - prescaler runs straight from the system clock and clocks the counter; slave mode 111 bypasses it
// - reload preload enable clear: reload writes act at once; set: buffered
// - one-pulse clears count enable at next update; count enable starts counter
// - update source select 1 limits update requests to overflow only
// - update inhibit clear: overflow or software request makes update, loads shadows
// - update inhibit set: no update, shadows kept; software request still reinits
// - master select 000 puts software update request or slave mode reset on trigger output
// - master select 001 puts counter enable on trigger output
// - master select 010 puts update event on trigger output; rest reserved
// - master slave sync delays trigger input effect by one cycle
// - trigger source select picks one of four internal triggers
// - slave mode 000 disables slave control; prescaler runs from clock
// - slave mode 100: rising trigger reinitializes counter and makes update
// - slave mode 101: counter counts only while trigger is high
// - slave mode 110: rising trigger sets count enable without reset
// - slave mode 111: each rising trigger edge advances the counter while count enable is set
// - update dma enable requests dma under same conditions as update flag
// - two interrupt sources, update and trigger, each with enable bit
// - trigger interrupt enable gates trigger interrupt request
// - software update request reinitializes counter and prescaler, self-clears
// - trigger flag set on active trigger edge, both edges gated; software clears
`ifndef B8T_DEFS_SVH
`define B8T_DEFS_SVH
`define B8T_OFF_CTRL1 12'h000
`define B8T_OFF_CTRL2 12'h004
`define B8T_OFF_SMODE 12'h008
`define B8T_OFF_DMAEN 12'h00C
`define B8T_OFF_IRQEN 12'h010
`define B8T_OFF_STAT 12'h014
`define B8T_OFF_EVGEN 12'h018
`define B8T_OFF_CNT 12'h01C
`define B8T_OFF_PRESCALE 12'h020
`define B8T_OFF_RELOAD 12'h024
`define B8T_RST_RELOAD 8'hFF
`define B8T_BIT_RLPRE 7
`define B8T_BIT_ONEPULSE 3
`define B8T_BIT_UPDSRC 2
`define B8T_BIT_UPDINH 1
`define B8T_BIT_CNTEN 0
`define B8T_BIT_MSSYNC 7
`define B8T_BIT_TFLAG 6
`define B8T_BIT_UFLAG 0
`define B8T_BIT_TGEN 6
`define B8T_BIT_UGEN 0
`endif

// ### pkg/b8t_pkg.sv
// types of the basic timer
package b8t_pkg;
  typedef enum logic [2:0] {
    B8T_SLV_OFF = 3'b000,
    B8T_SLV_RESET = 3'b100,
    B8T_SLV_GATED = 3'b101,
    B8T_SLV_TRIG = 3'b110,
    B8T_SLV_EXTCK = 3'b111
  } b8t_slave_type;
  typedef enum logic [2:0] {
    B8T_MST_RESET = 3'b000,
    B8T_MST_ENABLE = 3'b001,
    B8T_MST_UPDATE = 3'b010
  } b8t_master_type;
  typedef struct packed {
    logic update_irq;
    logic trigger_irq;
    logic update_dma;
    logic trigger_out;
  } b8t_events_type;
endpackage

// ### rtl/b8t_sync.sv
`timescale 1ns/10ps
// two flip-flop synchroniser with rising and falling edge detect
module b8t_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // signal
  input wire logic din,
  output logic dout,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  assign dout = sync_r;
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule // b8t_sync

// ### rtl/b8t_prescaler.sv
`timescale 1ns/10ps
// power-of-two prescaler producing counter clock ticks
module b8t_prescaler #(
  parameter int PW = 16,
  parameter int SW = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic [SW-1:0] shift,
  // tick out
  output logic tick
);
  logic [PW-1:0] cnt_r;
  logic [PW-1:0] limit;
  logic at_limit;
  // divide by 2**shift; shift 0 ticks every cycle
  assign limit = (PW'(1) << shift) - PW'(1);
  assign at_limit = (cnt_r == limit);
  assign tick = run & at_limit & ~clear;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (clear || (run && at_limit)) begin
      cnt_r <= '0;
    end else if (run) begin
      cnt_r <= cnt_r + PW'(1);
    end
  end
endmodule // b8t_prescaler

// ### rtl/b8t_timer.sv
`timescale 1ns/10ps
`include "b8t_defs.svh"
// 8-bit basic timer with apb register slave
module b8t_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal triggers from other timers
  input wire logic [3:0] internal_trigger,
  // events
  output b8t_pkg::b8t_events_type events
);
  import b8t_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl1_r;
  logic [2:0] master_sel_r;
  logic [7:0] smode_r;
  logic dma_en_r;
  logic trig_irq_en_r;
  logic upd_irq_en_r;
  logic tflag_r;
  logic uflag_r;
  logic [7:0] cnt_r;
  logic [3:0] presc_pre_r;
  logic [3:0] presc_act_r;
  logic [7:0] reload_pre_r;
  logic [7:0] reload_act_r;
  logic msm_dly_rise_r;
  logic msm_dly_level_r;
  logic msm_dly_fall_r;
  logic [31:0] prdata_r;
  b8t_events_type events_r;

  ////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, unmapped addresses answer slverr
  logic wr_en;
  logic rd_en;
  logic hit_ctrl1, hit_ctrl2, hit_smode, hit_dmaen, hit_irqen;
  logic hit_stat, hit_evgen, hit_cnt, hit_presc, hit_reload, hit_any;
  assign hit_ctrl1 = (paddr == `B8T_OFF_CTRL1);
  assign hit_ctrl2 = (paddr == `B8T_OFF_CTRL2);
  assign hit_smode = (paddr == `B8T_OFF_SMODE);
  assign hit_dmaen = (paddr == `B8T_OFF_DMAEN);
  assign hit_irqen = (paddr == `B8T_OFF_IRQEN);
  assign hit_stat = (paddr == `B8T_OFF_STAT);
  assign hit_evgen = (paddr == `B8T_OFF_EVGEN);
  assign hit_cnt = (paddr == `B8T_OFF_CNT);
  assign hit_presc = (paddr == `B8T_OFF_PRESCALE);
  assign hit_reload = (paddr == `B8T_OFF_RELOAD);
  assign hit_any = hit_ctrl1 | hit_ctrl2 | hit_smode | hit_dmaen |
                   hit_irqen | hit_stat | hit_evgen | hit_cnt |
                   hit_presc | hit_reload;
  assign wr_en = psel & penable & pwrite & hit_any;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  logic [7:0] rd_mux;
  assign rd_mux =
    hit_ctrl1 ? {ctrl1_r[7], 3'b000, ctrl1_r[3:0]} :
    hit_ctrl2 ? {1'b0, master_sel_r, 4'h0} :
    hit_smode ? {smode_r[7:4], 1'b0, smode_r[2:0]} :
    hit_dmaen ? {7'h00, dma_en_r} :
    hit_irqen ? {1'b0, trig_irq_en_r, 5'h00, upd_irq_en_r} :
    hit_stat ? {1'b0, tflag_r, 5'h00, uflag_r} :
    hit_cnt ? cnt_r :
    hit_presc ? {4'h0, presc_pre_r} :
    hit_reload ? reload_pre_r : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // trigger input selection and synchronisation
  logic [1:0] trig_src_sel;
  logic [3:0] itr_lvl, itr_rise, itr_fall;
  logic trig_lvl_s, trig_rise_s, trig_fall_s;
  logic trig_lvl, trig_rise, trig_fall;
  logic trig_src_ok;
  b8t_slave_type smode;
  assign trig_src_ok = ~smode_r[6];                   // codes 1xx reserved
  assign trig_src_sel = smode_r[5:4];
  assign smode = b8t_slave_type'(smode_r[2:0]);

  // every trigger pin is synchronised before the selector reads it
  for (genvar g = 0; g < 4; g++) begin : g_trig_sync
    b8t_sync u_trig_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(internal_trigger[g]),
      .dout(itr_lvl[g]),
      .rise(itr_rise[g]),
      .fall(itr_fall[g])
    );
  end
  assign trig_lvl_s = trig_src_ok & itr_lvl[trig_src_sel];
  assign trig_rise_s = trig_src_ok & itr_rise[trig_src_sel];
  assign trig_fall_s = trig_src_ok & itr_fall[trig_src_sel];

  // optional one-cycle delay of trigger effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msm_dly_rise_r <= 1'b0;
      msm_dly_level_r <= 1'b0;
      msm_dly_fall_r <= 1'b0;
    end else begin
      msm_dly_rise_r <= trig_rise_s;
      msm_dly_level_r <= trig_lvl_s;
      msm_dly_fall_r <= trig_fall_s;
    end
  end
  assign trig_rise = smode_r[`B8T_BIT_MSSYNC] ? msm_dly_rise_r : trig_rise_s;
  assign trig_lvl = smode_r[`B8T_BIT_MSSYNC] ? msm_dly_level_r : trig_lvl_s;
  assign trig_fall = smode_r[`B8T_BIT_MSSYNC] ? msm_dly_fall_r : trig_fall_s;

  ////////////////////////////////////////////////////////////////////////
  // slave mode effects
  logic slave_reset, gated_on, trig_start, ext_edge, trig_event;
  assign slave_reset = (smode == B8T_SLV_RESET) & trig_rise;
  assign gated_on = (smode == B8T_SLV_GATED) & trig_lvl;
  assign trig_start = (smode == B8T_SLV_TRIG) & trig_rise;
  assign ext_edge = (smode == B8T_SLV_EXTCK) & trig_rise;
  // gated mode flags both edges, other slave modes the rising one
  assign trig_event = (smode == B8T_SLV_GATED) ? (trig_rise | trig_fall) :
                      (smode != B8T_SLV_OFF) & trig_rise;

  ////////////////////////////////////////////////////////////////////////
  // software events
  logic sw_update_request, sw_trig_gen;
  assign sw_update_request = wr_en & hit_evgen & pwdata[`B8T_BIT_UGEN];
  assign sw_trig_gen = wr_en & hit_evgen & pwdata[`B8T_BIT_TGEN];

  ////////////////////////////////////////////////////////////////////////
  // counting
  logic count_enable, counter_enable_sig, presc_run, presc_clear, presc_tick;
  logic cnt_tick, overflow, reinit, update_event, upd_req, flag_set_u;
  logic upd_inhibit, upd_src_sel;
  assign count_enable = ctrl1_r[`B8T_BIT_CNTEN];
  assign upd_inhibit = ctrl1_r[`B8T_BIT_UPDINH];
  assign upd_src_sel = ctrl1_r[`B8T_BIT_UPDSRC];
  // enable seen by other timers: bit or gated trigger
  assign counter_enable_sig = count_enable | gated_on;
  // external clock mode bypasses the prescaler; gated runs only while high
  assign presc_run = (smode == B8T_SLV_EXTCK) ? 1'b0 :
                     (smode == B8T_SLV_GATED) ? gated_on :
                     count_enable;
  assign reinit = sw_update_request | slave_reset;
  assign presc_clear = reinit;

  b8t_prescaler #(
    .PW(16),
    .SW(4)
  ) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .run(presc_run),
    .clear(presc_clear),
    .shift(presc_act_r),
    .tick(presc_tick)
  );

  assign cnt_tick = ((smode == B8T_SLV_EXTCK) ? (count_enable & ext_edge)
                                              : presc_tick) & ~reinit;
  assign overflow = cnt_tick & (cnt_r == reload_act_r);
  // update event from overflow or reinit unless inhibited
  assign update_event = ~upd_inhibit & (overflow | reinit);
  // request source: overflow only when selected
  assign upd_req = update_event & (~upd_src_sel | overflow);
  assign flag_set_u = upd_req;

  ////////////////////////////////////////////////////////////////////////
  // counter and shadow registers
  logic [7:0] reload_wdata;
  assign reload_wdata = pwdata[7:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
    end else if (reinit || overflow) begin
      cnt_r <= 8'h00;
    end else if (wr_en && hit_cnt) begin
      cnt_r <= pwdata[7:0];
    end else if (cnt_tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_pre_r <= 4'h0;
      presc_act_r <= 4'h0;
      reload_pre_r <= `B8T_RST_RELOAD;
      reload_act_r <= `B8T_RST_RELOAD;
    end else begin
      if (wr_en && hit_presc) begin
        presc_pre_r <= pwdata[3:0];
      end
      if (wr_en && hit_reload) begin
        reload_pre_r <= reload_wdata;
      end
      if (update_event) begin
        presc_act_r <= presc_pre_r;
      end
      // unbuffered reload takes writes at once
      if (wr_en && hit_reload && !ctrl1_r[`B8T_BIT_RLPRE]) begin
        reload_act_r <= reload_wdata;
      end else if (update_event) begin
        reload_act_r <= reload_pre_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  logic cnten_set, cnten_clr;
  assign cnten_set = trig_start;
  assign cnten_clr = ctrl1_r[`B8T_BIT_ONEPULSE] & update_event;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_r <= 8'h00;
      master_sel_r <= 3'b000;
      smode_r <= 8'h00;
      dma_en_r <= 1'b0;
      trig_irq_en_r <= 1'b0;
      upd_irq_en_r <= 1'b0;
    end else begin
      if (wr_en && hit_ctrl1) begin
        ctrl1_r <= {pwdata[7], 3'b000, pwdata[3:0]};
      end else if (cnten_set) begin
        ctrl1_r[`B8T_BIT_CNTEN] <= 1'b1;
      end else if (cnten_clr) begin
        ctrl1_r[`B8T_BIT_CNTEN] <= 1'b0;
      end
      if (wr_en && hit_ctrl2) begin
        master_sel_r <= pwdata[6:4];
      end
      if (wr_en && hit_smode) begin
        smode_r <= {pwdata[7:4], 1'b0, pwdata[2:0]};
      end
      if (wr_en && hit_dmaen) begin
        dma_en_r <= pwdata[0];
      end
      if (wr_en && hit_irqen) begin
        trig_irq_en_r <= pwdata[6];
        upd_irq_en_r <= pwdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags: write zero clears, a set in the same cycle wins
  logic stat_wr, tflag_set;
  assign stat_wr = wr_en & hit_stat;
  assign tflag_set = trig_event | sw_trig_gen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tflag_r <= 1'b0;
      uflag_r <= 1'b0;
    end else begin
      if (tflag_set) begin
        tflag_r <= 1'b1;
      end else if (stat_wr && !pwdata[`B8T_BIT_TFLAG]) begin
        tflag_r <= 1'b0;
      end
      if (flag_set_u) begin
        uflag_r <= 1'b1;
      end else if (stat_wr && !pwdata[`B8T_BIT_UFLAG]) begin
        uflag_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger output and request outputs
  logic trig_out_nxt;
  always_comb begin
    case (b8t_master_type'(master_sel_r))
      B8T_MST_RESET: trig_out_nxt = reinit;
      B8T_MST_ENABLE: trig_out_nxt = counter_enable_sig;
      B8T_MST_UPDATE: trig_out_nxt = update_event;
      default: trig_out_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events_r <= '0;
      prdata_r <= 32'h0000_0000;
    end else begin
      events_r.update_irq <= upd_irq_en_r & (uflag_r | flag_set_u);
      events_r.trigger_irq <= trig_irq_en_r & (tflag_r | tflag_set);
      events_r.update_dma <= dma_en_r & flag_set_u;
      events_r.trigger_out <= trig_out_nxt;
      if (rd_en) begin
        prdata_r <= {24'h00_0000, rd_mux};
      end
    end
  end
  assign events = events_r;
  assign prdata = prdata_r;
endmodule // b8t_timer

// ### test/b8t_timer_assertions.sv
`timescale 1ns/10ps
`include "b8t_defs.svh"
// concurrent checks on the basic timer ports
module b8t_timer_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // triggers and events
  input wire logic [3:0] internal_trigger,
  input wire b8t_pkg::b8t_events_type events
);
  import b8t_pkg::*;
  logic [2:0] master_sel_r;
  logic dma_en_sh_r;
  wire wr_take = psel && penable && pwrite;
  wire master_res = (master_sel_r > 3'b010);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // shadow copies of the fields that steer outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_sel_r <= 3'b000;
      dma_en_sh_r <= 1'b0;
    end else if (wr_take && paddr == `B8T_OFF_CTRL2) begin
      master_sel_r <= pwdata[6:4];
    end else if (wr_take && paddr == `B8T_OFF_DMAEN) begin
      dma_en_sh_r <= pwdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  slverr_map_a: assert property (
    psel && penable |-> pslverr == (paddr > `B8T_OFF_RELOAD))
    else $error("pslverr does not match address decode");
  slverr_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  ready_access_a: assert property (psel && penable |-> pready)
    else $error("access phase not answered");
  dma_pulse_a: assert property (
    events.update_dma |=> !events.update_dma)
    else $error("dma request longer than one cycle");
  dma_off_a: assert property (
    !dma_en_sh_r && !$past(dma_en_sh_r) && !$past(dma_en_sh_r, 2)
    |-> !events.update_dma)
    else $error("dma request while disabled");
  uirq_mask_a: assert property (
    wr_take && paddr == `B8T_OFF_IRQEN && !pwdata[0]
    |-> ##2 !events.update_irq)
    else $error("update interrupt not masked");
  tirq_mask_a: assert property (
    wr_take && paddr == `B8T_OFF_IRQEN && !pwdata[6]
    |-> ##2 !events.trigger_irq)
    else $error("trigger interrupt not masked");
  trout_res_a: assert property (
    master_res && $past(master_res) && $past(master_res, 2)
    |-> !events.trigger_out)
    else $error("trigger output active in reserved mode");
  ug_trout_a: assert property (
    wr_take && paddr == `B8T_OFF_EVGEN && pwdata[0] && master_sel_r == 3'b000
    |-> ##[1:4] events.trigger_out)
    else $error("software update not seen on trigger output");
endmodule // b8t_timer_assertions

bind b8t_timer b8t_timer_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .internal_trigger(internal_trigger), .events(events));

// ### test/b8t_timer_tb.sv
`timescale 1ns/10ps
`include "b8t_defs.svh"
// self-checking bench for the basic timer
module b8t_timer_tb;
  import b8t_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} b8t_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, rw;
  logic [3:0] internal_trigger;
  b8t_events_type events;
  int n_errors, checked, n;
  logic e;
  b8t_row_type rows [12] = '{
    '{`B8T_OFF_CTRL1, 32'h0000_00FF, 32'h0000_008F},
    '{`B8T_OFF_CTRL1, 32'h0000_0000, 32'h0000_0000},
    '{`B8T_OFF_CTRL2, 32'h0000_00FF, 32'h0000_0070},
    '{`B8T_OFF_CTRL2, 32'h0000_0000, 32'h0000_0000},
    '{`B8T_OFF_SMODE, 32'h0000_00FF, 32'h0000_00F7},
    '{`B8T_OFF_SMODE, 32'h0000_0000, 32'h0000_0000},
    '{`B8T_OFF_DMAEN, 32'h0000_00FF, 32'h0000_0001},
    '{`B8T_OFF_EVGEN, 32'h0000_00FF, 32'h0000_0000},
    '{`B8T_OFF_STAT, 32'h0000_0000, 32'h0000_0000},
    '{`B8T_OFF_IRQEN, 32'h0000_00FF, 32'h0000_0041},
    '{`B8T_OFF_IRQEN, 32'h0000_0000, 32'h0000_0000},
    '{`B8T_OFF_PRESCALE, 32'h0000_00FF, 32'h0000_000F}};
  b8t_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_trigger(internal_trigger), .events(events));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task automatic final_report;
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, then an idle edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rw, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0000_0000, rv, e);
    chk("register read", rv, x);
  endtask
  task automatic wait_dma(input int lim, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (events.update_dma !== 1'b1 && c < lim);
  endtask
  initial begin
    #(40 * 20000);
    n_errors++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    checked = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    internal_trigger = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 'h24; a += 4)
      rd(12'(a), (a == 'h24) ? 32'h0000_00FF : 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    xfer(1'b1, 12'h030, 32'h0000_00FF, rv, e);
    chk("unmapped error", 32'(e), 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      wr(`B8T_OFF_RELOAD, 32'h0000_0003);
      wr(`B8T_OFF_PRESCALE, 32'(k == 2 ? 3 : k));
      wr(`B8T_OFF_EVGEN, 32'h0000_0001);
      wr(`B8T_OFF_CTRL1, 32'h0000_0001);
      repeat (3) wait_dma(2000, n);
      chk("overflow period", 32'(n), 32'(4 << (k == 2 ? 3 : k)));
      wr(`B8T_OFF_CTRL1, 32'h0000_0000);
    end
    wr(`B8T_OFF_CTRL1, 32'h0000_0009);
    wait_dma(2000, n);
    repeat (4) @(posedge pclk);
    rd(`B8T_OFF_CTRL1, 32'h0000_0008);
    wr(`B8T_OFF_CTRL1, 32'h0000_0003);
    wait_dma(100, n);
    chk("inhibited update", 32'(n), 32'd100);
    wr(`B8T_OFF_STAT, 32'h0000_0000);
    wr(`B8T_OFF_CTRL1, 32'h0000_0004);
    fork
      wr(`B8T_OFF_EVGEN, 32'h0000_0001);
      wait_dma(20, n);
    join
    chk("overflow only", 32'(n), 32'd20);
    rd(`B8T_OFF_STAT, 32'h0000_0000);
    wr(`B8T_OFF_CTRL1, 32'h0000_0000);
    wr(`B8T_OFF_IRQEN, 32'h0000_0001);
    fork
      wr(`B8T_OFF_EVGEN, 32'h0000_0001);
      wait_dma(20, n);
    join
    chk("update dma", 32'(n < 20), 32'd1);
    rd(`B8T_OFF_STAT, 32'h0000_0001);
    chk("update irq", 32'(events.update_irq), 32'd1);
    wr(`B8T_OFF_IRQEN, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("update irq off", 32'(events.update_irq), 32'd0);
    wr(`B8T_OFF_STAT, 32'h0000_0000);
    wr(`B8T_OFF_SMODE, 32'h0000_0024);
    wr(`B8T_OFF_IRQEN, 32'h0000_0040);
    internal_trigger <= 4'b0100;
    repeat (8) @(posedge pclk);
    chk("trigger irq", 32'(events.trigger_irq), 32'd1);
    rd(`B8T_OFF_STAT, 32'h0000_0041);
    wr(`B8T_OFF_SMODE, 32'h0000_0025);
    wr(`B8T_OFF_STAT, 32'h0000_0000);
    xfer(1'b0, `B8T_OFF_CNT, 32'h0000_0000, rw, e);
    repeat (40) @(posedge pclk);
    xfer(1'b0, `B8T_OFF_CNT, 32'h0000_0000, rv, e);
    chk("gated counts", 32'(rv !== rw), 32'd1);
    internal_trigger <= 4'b0000;
    repeat (8) @(posedge pclk);
    xfer(1'b0, `B8T_OFF_CNT, 32'h0000_0000, rw, e);
    repeat (40) @(posedge pclk);
    rd(`B8T_OFF_CNT, rw);
    rd(`B8T_OFF_STAT, 32'h0000_0041);
    wr(`B8T_OFF_SMODE, 32'h0000_0026);
    internal_trigger <= 4'b0100;
    repeat (8) @(posedge pclk);
    rd(`B8T_OFF_CTRL1, 32'h0000_0001);
    wr(`B8T_OFF_CTRL2, 32'h0000_0010);
    repeat (3) @(posedge pclk);
    chk("enable out", 32'(events.trigger_out), 32'd1);
    wr(`B8T_OFF_CTRL2, 32'h0000_0030);
    repeat (3) @(posedge pclk);
    chk("reserved out", 32'(events.trigger_out), 32'd0);
    wr(`B8T_OFF_SMODE, 32'h0000_0027);
    xfer(1'b0, `B8T_OFF_CNT, 32'h0000_0000, rw, e);
    repeat (3) begin
      internal_trigger <= 4'b0000;
      repeat (4) @(posedge pclk);
      internal_trigger <= 4'b0100;
      repeat (4) @(posedge pclk);
    end
    rd(`B8T_OFF_CNT, (rw + 32'd3) & 32'h0000_0003);
    final_report();
  end
endmodule // b8t_timer_tb
